// ===== pkg/tei_map.svh
// register map, field positions, reset values and counts of the timer pin block
`ifndef TEI_MAP_SVH
`define TEI_MAP_SVH

`define TEI_OFS_CTRL 8'h00
`define TEI_OFS_STATUS 8'h04
`define TEI_OFS_CLEAR 8'h08
`define TEI_OFS_IRQEN 8'h0c
`define TEI_OFS_CNTA 8'h10
`define TEI_OFS_CNTB 8'h14
`define TEI_OFS_CNTC 8'h18
`define TEI_OFS_RELC 8'h1c
`define TEI_OFS_CAPC 8'h20

`define TEI_CTRL_RUNA 0
`define TEI_CTRL_GATEA 1
`define TEI_CTRL_CNTMA 2
`define TEI_CTRL_RUNB 3
`define TEI_CTRL_GATEB 4
`define TEI_CTRL_CNTMB 5
`define TEI_CTRL_TYPEA 6
`define TEI_CTRL_TYPEB 7
`define TEI_CTRL_RUNC 8
`define TEI_CTRL_CNTMC 9
`define TEI_CTRL_CLKOC 10
`define TEI_CTRL_AUXEN 11
`define TEI_CTRL_AUXM 12
`define TEI_CTRL_IDLE 14
`define TEI_CTRL_PDOWN 15

`define TEI_AUX_RELOAD 2'h0
`define TEI_AUX_CAPTURE 2'h1
`define TEI_AUX_DIR 2'h2

`define TEI_ST_IRQA 0
`define TEI_ST_IRQB 1
`define TEI_ST_OVFA 2
`define TEI_ST_OVFB 3
`define TEI_ST_OVFC 4
`define TEI_ST_AUXC 5

`define TEI_CTRL_RST 16'h0000
`define TEI_CNT_MAX 16'hffff
`define TEI_TICK_DIV 6
`define TEI_PIN_IRQA 0
`define TEI_PIN_IRQB 1
`define TEI_PIN_CNTA 2
`define TEI_PIN_CNTB 3
`define TEI_PIN_CLKC 4
`define TEI_PIN_AUXC 5

`endif

// ===== pkg/tei_pkg.sv
// types shared by the timer pin block
package tei_pkg;
	typedef struct packed {
		logic [15:0] cntA;
		logic [15:0] cntB;
		logic [15:0] cntC;
		logic [15:0] reloadC;
		logic [15:0] captureC;
		logic [15:0] ctrl;
		logic [5:0] status;
		logic [5:0] irqEn;
		logic [2:0] divCnt;
		logic clkOut;
		logic [31:0] rdata;
	} tei_state_t;
endpackage

// ===== design/tei_pin_sync.sv
// pin synchroniser with falling-edge detection
module tei_pin_sync #(
	parameter int N = 6
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [N-1:0] pins,
	output logic [N-1:0] level,
	output logic [N-1:0] fall
);
	typedef struct packed {
		logic [N-1:0] meta;
		logic [N-1:0] stable;
		logic [N-1:0] prev;
	} tei_sync_t;

	tei_sync_t st;
	tei_sync_t next_st;

	if (N < 1) begin : g_chk
		$error("tei_pin_sync needs at least one pin");
	end

	always_comb begin
		next_st = st;
		next_st.meta = pins;
		next_st.stable = st.meta;
		next_st.prev = st.stable;
	end

	// reset high so an idle pin gives no false edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	for (genvar i = 0; i < N; i++) begin : g_pin
		assign level[i] = st.stable[i];
		assign fall[i] = st.prev[i] & ~st.stable[i];
	end
endmodule

// ===== design/tei_timers.sv
// timers 0/1/2 with external pin logic, interrupt flags and apb registers
`include "tei_map.svh"
module tei_timers #(
	parameter int TickDiv = `TEI_TICK_DIV
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic extIrqPinA,
	input wire logic extIrqPinB,
	input wire logic timerACountPin,
	input wire logic timerBCountPin,
	input wire logic timerCClkPinIn,
	output logic timerCClkPinOut,
	output logic timerCClkPinOe_n,
	input wire logic timerCAuxPin,
	output logic irq,
	output logic cpuHalt,
	output logic periphClkOn
);
	import tei_pkg::*;

	tei_pkg::tei_state_t st;
	tei_pkg::tei_state_t next_st;
	logic [5:0] lvl;
	logic [5:0] fall;
	logic mapped;
	logic setup;
	logic wrEn;
	logic tick;
	logic pd;
	logic runA;
	logic runB;
	logic stepA;
	logic stepB;
	logic stepC;
	logic downC;
	logic [1:0] auxMode;
	logic [5:0] setBits;
	logic [5:0] clrBits;

	if (TickDiv < 2 || TickDiv > 8) begin : g_chk
		$error("TickDiv must lie between 2 and 8");
	end

	tei_pin_sync #(
		.N(6)
	) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pins({timerCAuxPin, timerCClkPinIn, timerBCountPin,
			timerACountPin, extIrqPinB, extIrqPinA}),
		.level(lvl),
		.fall(fall)
	);

	always_comb begin
		case (paddr)
			`TEI_OFS_CTRL, `TEI_OFS_STATUS, `TEI_OFS_CLEAR,
			`TEI_OFS_IRQEN, `TEI_OFS_CNTA, `TEI_OFS_CNTB,
			`TEI_OFS_CNTC, `TEI_OFS_RELC, `TEI_OFS_CAPC: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign setup = psel & ~penable;
	assign wrEn = psel & penable & pwrite & mapped;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = st.rdata;

	// peripheral clock frozen in power-down
	assign pd = st.ctrl[`TEI_CTRL_PDOWN];
	assign tick = (st.divCnt == 3'(TickDiv - 1)) & ~pd;

	assign runA = st.ctrl[`TEI_CTRL_RUNA] & ~pd &
		(~st.ctrl[`TEI_CTRL_GATEA] | lvl[`TEI_PIN_IRQA]);
	assign runB = st.ctrl[`TEI_CTRL_RUNB] & ~pd &
		(~st.ctrl[`TEI_CTRL_GATEB] | lvl[`TEI_PIN_IRQB]);
	assign stepA = runA & (st.ctrl[`TEI_CTRL_CNTMA] ?
		fall[`TEI_PIN_CNTA] : tick);
	assign stepB = runB & (st.ctrl[`TEI_CTRL_CNTMB] ?
		fall[`TEI_PIN_CNTB] : tick);
	// an external clock only makes sense while the pin is not driven
	assign stepC = st.ctrl[`TEI_CTRL_RUNC] & ~pd &
		((st.ctrl[`TEI_CTRL_CNTMC] & ~st.ctrl[`TEI_CTRL_CLKOC]) ?
		fall[`TEI_PIN_CLKC] : tick);
	assign auxMode = st.ctrl[`TEI_CTRL_AUXM +: 2];
	assign downC = st.ctrl[`TEI_CTRL_AUXEN] &
		(auxMode == `TEI_AUX_DIR) & ~lvl[`TEI_PIN_AUXC];

	always_comb begin
		setBits = '0;
		setBits[`TEI_ST_IRQA] = st.ctrl[`TEI_CTRL_TYPEA] ?
			fall[`TEI_PIN_IRQA] : ~lvl[`TEI_PIN_IRQA];
		setBits[`TEI_ST_IRQB] = st.ctrl[`TEI_CTRL_TYPEB] ?
			fall[`TEI_PIN_IRQB] : ~lvl[`TEI_PIN_IRQB];
		setBits[`TEI_ST_OVFA] = stepA & (st.cntA == `TEI_CNT_MAX);
		setBits[`TEI_ST_OVFB] = stepB & (st.cntB == `TEI_CNT_MAX);
		setBits[`TEI_ST_OVFC] = stepC & (downC ?
			(st.cntC == st.reloadC) : (st.cntC == `TEI_CNT_MAX));
		// aux events need the peripheral clock, so none in power-down
		setBits[`TEI_ST_AUXC] = st.ctrl[`TEI_CTRL_AUXEN] & ~pd &
			(auxMode != `TEI_AUX_DIR) & fall[`TEI_PIN_AUXC];
		clrBits = (wrEn && paddr == `TEI_OFS_CLEAR) ? pwdata[5:0] : '0;
	end

	always_comb begin
		next_st = st;
		next_st.divCnt = pd ? st.divCnt :
			(tick ? 3'h0 : 3'(st.divCnt + 3'h1));
		// 16-bit counts of timers a and b wrap naturally; timer c reloads at its ends
		if (stepA) begin
			next_st.cntA = 16'(st.cntA + 16'h1);
		end
		if (stepB) begin
			next_st.cntB = 16'(st.cntB + 16'h1);
		end
		if (stepC) begin
			if (downC) begin
				next_st.cntC = (st.cntC == st.reloadC) ? `TEI_CNT_MAX :
					16'(st.cntC - 16'h1);
			end else begin
				next_st.cntC = (st.cntC == `TEI_CNT_MAX) ? st.reloadC :
					16'(st.cntC + 16'h1);
			end
		end
		if (setBits[`TEI_ST_OVFC] && st.ctrl[`TEI_CTRL_CLKOC]) begin
			next_st.clkOut = ~st.clkOut;
		end
		if (setBits[`TEI_ST_AUXC]) begin
			if (auxMode == `TEI_AUX_RELOAD) begin
				next_st.cntC = st.reloadC;
			end else begin
				next_st.captureC = st.cntC;
			end
		end
		// set wins over a clear in the same cycle
		next_st.status = (st.status & ~clrBits) | setBits;
		// idle and power-down both end on an enabled interrupt
		if (|(st.status & st.irqEn) || |(setBits[1:0] & st.irqEn[1:0])) begin
			next_st.ctrl[`TEI_CTRL_IDLE] = 1'b0;
			next_st.ctrl[`TEI_CTRL_PDOWN] = 1'b0;
		end
		if (wrEn) begin
			case (paddr)
				`TEI_OFS_CTRL: next_st.ctrl = pwdata[15:0];
				`TEI_OFS_IRQEN: next_st.irqEn = pwdata[5:0];
				`TEI_OFS_CNTA: next_st.cntA = pwdata[15:0];
				`TEI_OFS_CNTB: next_st.cntB = pwdata[15:0];
				`TEI_OFS_CNTC: next_st.cntC = pwdata[15:0];
				`TEI_OFS_RELC: next_st.reloadC = pwdata[15:0];
				default: next_st.irqEn = st.irqEn;
			endcase
		end
		if (setup) begin
			case (paddr)
				`TEI_OFS_CTRL: next_st.rdata = {16'h0, st.ctrl};
				`TEI_OFS_STATUS: next_st.rdata = {26'h0, st.status};
				`TEI_OFS_IRQEN: next_st.rdata = {26'h0, st.irqEn};
				`TEI_OFS_CNTA: next_st.rdata = {16'h0, st.cntA};
				`TEI_OFS_CNTB: next_st.rdata = {16'h0, st.cntB};
				`TEI_OFS_CNTC: next_st.rdata = {16'h0, st.cntC};
				`TEI_OFS_RELC: next_st.rdata = {16'h0, st.reloadC};
				`TEI_OFS_CAPC: next_st.rdata = {16'h0, st.captureC};
				default: next_st.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign irq = |(st.status & st.irqEn);
	assign timerCClkPinOut = st.clkOut;
	assign timerCClkPinOe_n = ~st.ctrl[`TEI_CTRL_CLKOC];
	assign cpuHalt = st.ctrl[`TEI_CTRL_IDLE] | pd;
	assign periphClkOn = ~pd;

	logic wrCntA;
	logic wrCntB;
	logic wrCntC;
	assign wrCntA = wrEn && paddr == `TEI_OFS_CNTA;
	assign wrCntB = wrEn && paddr == `TEI_OFS_CNTB;
	assign wrCntC = wrEn && paddr == `TEI_OFS_CNTC;
	logic wrCtrl;
	assign wrCtrl = wrEn && paddr == `TEI_OFS_CTRL;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_gate_a;
		st.ctrl[`TEI_CTRL_GATEA] && !lvl[`TEI_PIN_IRQA] && !wrCntA
			|=> $stable(st.cntA);
	endproperty
	a_gate_a: assert property (p_gate_a)
		else $error("timer a moved while gated off");

	property p_edge_a;
		st.ctrl[`TEI_CTRL_TYPEA] && $past(lvl[`TEI_PIN_IRQA]) &&
			!lvl[`TEI_PIN_IRQA] |=> st.status[`TEI_ST_IRQA];
	endproperty
	a_edge_a: assert property (p_edge_a)
		else $error("falling edge on pin a did not set flag a");

	property p_level_a;
		!st.ctrl[`TEI_CTRL_TYPEA] && !lvl[`TEI_PIN_IRQA]
			|=> st.status[`TEI_ST_IRQA];
	endproperty
	a_level_a: assert property (p_level_a)
		else $error("low level on pin a did not set flag a");

	property p_gate_b;
		st.ctrl[`TEI_CTRL_GATEB] && !lvl[`TEI_PIN_IRQB] && !wrCntB
			|=> $stable(st.cntB);
	endproperty
	a_gate_b: assert property (p_gate_b)
		else $error("timer b moved while gated off");

	property p_edge_b;
		st.ctrl[`TEI_CTRL_TYPEB] && fall[`TEI_PIN_IRQB]
			|=> st.status[`TEI_ST_IRQB];
	endproperty
	a_edge_b: assert property (p_edge_b)
		else $error("falling edge on pin b did not set flag b");

	property p_level_b;
		!st.ctrl[`TEI_CTRL_TYPEB] && !lvl[`TEI_PIN_IRQB]
			|=> st.status[`TEI_ST_IRQB];
	endproperty
	a_level_b: assert property (p_level_b)
		else $error("low level on pin b did not set flag b");

	property p_count_a;
		runA && st.ctrl[`TEI_CTRL_CNTMA] && fall[`TEI_PIN_CNTA] && !wrCntA
			|=> st.cntA == 16'($past(st.cntA) + 16'h1);
	endproperty
	a_count_a: assert property (p_count_a)
		else $error("count pin a edge not counted");

	property p_count_b;
		st.ctrl[`TEI_CTRL_CNTMB] && !fall[`TEI_PIN_CNTB] && !wrCntB
			|=> $stable(st.cntB);
	endproperty
	a_count_b: assert property (p_count_b)
		else $error("timer b counted without a pin edge");

	property p_pdown;
		pd && !wrCntC ##1 !wrCntC |-> $stable(st.cntC);
	endproperty
	a_pdown: assert property (p_pdown)
		else $error("timer c ran in power-down");

	property p_idle_run;
		st.ctrl[`TEI_CTRL_IDLE] && runA && !st.ctrl[`TEI_CTRL_CNTMA] &&
			tick && !wrCntA |=> st.cntA == 16'($past(st.cntA) + 16'h1);
	endproperty
	a_idle_run: assert property (p_idle_run)
		else $error("timer a stalled in idle");

	property p_wake;
		pd && st.ctrl[`TEI_CTRL_TYPEA] && fall[`TEI_PIN_IRQA] &&
			st.irqEn[`TEI_ST_IRQA] && !wrCtrl |=> !pd;
	endproperty
	a_wake: assert property (p_wake)
		else $error("enabled pin a edge did not end power-down");

	property p_down_c;
		stepC && downC && st.cntC != st.reloadC && !wrCntC
			|=> st.cntC == 16'($past(st.cntC) - 16'h1);
	endproperty
	a_down_c: assert property (p_down_c)
		else $error("timer c did not count down");

	property p_clk_out;
		setBits[`TEI_ST_OVFC] && st.ctrl[`TEI_CTRL_CLKOC]
			|=> timerCClkPinOut != $past(timerCClkPinOut);
	endproperty
	a_clk_out: assert property (p_clk_out)
		else $error("clock out did not toggle on overflow");
endmodule

// ===== verif/tei_pin_src.sv
// board-side source model driving the timer and interrupt pins
module tei_pin_src (
	input wire logic [5:0] reqLvl,
	input wire logic clkOut,
	input wire logic clkOe_n,
	output logic irqPinA,
	output logic irqPinB,
	output logic cntPinA,
	output logic cntPinB,
	output logic clkPin,
	output logic auxPin
);
	assign irqPinA = reqLvl[0];
	assign irqPinB = reqLvl[1];
	assign cntPinA = reqLvl[2];
	assign cntPinB = reqLvl[3];
	// source backs off while the block drives the shared pin
	assign clkPin = clkOe_n ? reqLvl[4] : clkOut;
	assign auxPin = reqLvl[5];
endmodule

// ===== verif/tei_timers_tb_top.sv
// self-checking bench of the timer pin block over apb
`include "tei_map.svh"
module tei_timers_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic irq, cpuHalt, periphClkOn, pA, pB, cA, cB, cIn, aux, cOut, cOe_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] lvl;
	int error_cnt, cmp_count, cyc;

	tei_timers dut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.extIrqPinA(pA), .extIrqPinB(pB), .timerACountPin(cA),
		.timerBCountPin(cB), .timerCClkPinIn(cIn), .timerCClkPinOut(cOut),
		.timerCClkPinOe_n(cOe_n), .timerCAuxPin(aux), .irq(irq),
		.cpuHalt(cpuHalt), .periphClkOn(periphClkOn));
	tei_pin_src src (.reqLvl(lvl), .clkOut(cOut), .clkOe_n(cOe_n),
		.irqPinA(pA), .irqPinB(pB), .cntPinA(cA), .cntPinB(cB),
		.clkPin(cIn), .auxPin(aux));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			wrap_up;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, m);
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task fall(input int i);
		@(posedge clk);
		lvl[i] <= 1'b0;
		tick(2);
		lvl[i] <= 1'b1;
		tick(1);
	endtask

	initial begin
		reset_n = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		lvl = 6'h3f;
		tick(3);
		reset_n <= 1'b1;
		tick(3);
		rdc(`TEI_OFS_CTRL, 32'h0, "ctrl reset");
		chk({31'h0, periphClkOn}, 32'h1, "clock on after reset");
		apb(1'b0, 8'h24, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped slverr");
		$display("test reset done");
		wr(`TEI_OFS_IRQEN, 32'h3);
		for (int i = 0; i < 2; i++) begin
			// edge mode: flag set once, stays clear while pin held low
			wr(`TEI_OFS_CTRL, 32'h40 << i);
			@(posedge clk) lvl[i] <= 1'b0;
			tick(4);
			rdc(`TEI_OFS_STATUS, 32'h1 << i, "edge flag");
			chk({31'h0, irq}, 32'h1, "irq level");
			wr(`TEI_OFS_CLEAR, 32'h1 << i);
			tick(2);
			rdc(`TEI_OFS_STATUS, 32'h0, "edge no reset");
			// level mode: flag comes back while pin is low
			wr(`TEI_OFS_CTRL, 32'h0);
			wr(`TEI_OFS_CLEAR, 32'h1 << i);
			tick(2);
			rdc(`TEI_OFS_STATUS, 32'h1 << i, "level flag");
			@(posedge clk) lvl[i] <= 1'b1;
			tick(4);
			wr(`TEI_OFS_CLEAR, 32'h3);
			tick(2);
			rdc(`TEI_OFS_STATUS, 32'h0, "level gone");
			chk({31'h0, irq}, 32'h0, "irq low");
		end
		$display("test ext irq done");
		for (int i = 0; i < 2; i++) begin
			wr(`TEI_OFS_CTRL, i ? 32'h28 : 32'h5);
			repeat (5) fall(2 + i);
			tick(4);
			rdc(`TEI_OFS_CNTA + 8'(4 * i), 32'h5, "pin count");
			wr(`TEI_OFS_CTRL, 32'h0);
			wr(`TEI_OFS_CNTA + 8'(4 * i), 32'h0);
			@(posedge clk) lvl[i] <= 1'b0;
			wr(`TEI_OFS_CTRL, i ? 32'h18 : 32'h3);
			tick(30);
			rdc(`TEI_OFS_CNTA + 8'(4 * i), 32'h0, "gated stop");
			@(posedge clk) lvl[i] <= 1'b1;
			tick(30);
			apb(1'b0, `TEI_OFS_CNTA + 8'(4 * i), 32'h0);
			chk({31'h0, rd != 0}, 32'h1, "gated run");
			wr(`TEI_OFS_CTRL, 32'h0);
		end
		wr(`TEI_OFS_CNTA, 32'hffff);
		rdc(`TEI_OFS_CNTA, 32'hffff, "16 bit count");
		wr(`TEI_OFS_CLEAR, 32'h3f);
		wr(`TEI_OFS_CTRL, 32'h5);
		fall(2);
		tick(4);
		rdc(`TEI_OFS_CNTA, 32'h0, "16 bit wrap");
		rdc(`TEI_OFS_STATUS, 32'h4, "overflow a");
		wr(`TEI_OFS_CTRL, 32'h0);
		$display("test counters done");
		wr(`TEI_OFS_RELC, 32'h1234);
		wr(`TEI_OFS_CLEAR, 32'h3f);
		wr(`TEI_OFS_CTRL, 32'h0800);
		fall(5);
		tick(4);
		rdc(`TEI_OFS_CNTC, 32'h1234, "aux reload");
		rdc(`TEI_OFS_STATUS, 32'h20, "aux flag");
		wr(`TEI_OFS_CNTC, 32'h42);
		wr(`TEI_OFS_CTRL, 32'h1800);
		fall(5);
		tick(4);
		rdc(`TEI_OFS_CAPC, 32'h42, "aux capture");
		wr(`TEI_OFS_CNTC, 32'h0);
		wr(`TEI_OFS_CTRL, 32'h0300);
		repeat (3) fall(4);
		tick(4);
		rdc(`TEI_OFS_CNTC, 32'h3, "ext clock count");
		wr(`TEI_OFS_CLEAR, 32'h3f);
		wr(`TEI_OFS_CNTC, 32'h1236);
		@(posedge clk) lvl[5] <= 1'b0;
		tick(4);
		wr(`TEI_OFS_CTRL, 32'h2b00);
		repeat (2) fall(4);
		tick(4);
		rdc(`TEI_OFS_CNTC, 32'h1234, "count down");
		fall(4);
		tick(4);
		rdc(`TEI_OFS_CNTC, 32'hffff, "down reload");
		rdc(`TEI_OFS_STATUS, 32'h10, "overflow c");
		@(posedge clk) lvl[5] <= 1'b1;
		wr(`TEI_OFS_CTRL, 32'h0500);
		tick(8);
		chk({31'h0, cOe_n}, 32'h0, "clock pin driven");
		chk({31'h0, cOut}, 32'h1, "clock out toggled");
		$display("test timer c done");
		wr(`TEI_OFS_CLEAR, 32'h3f);
		wr(`TEI_OFS_IRQEN, 32'h1);
		for (int k = 0; k < 2; k++) begin
			// timer a runs through idle so the idle check sees ticks
			wr(`TEI_OFS_CTRL, k ? 32'h8040 : 32'h4041);
			tick(6);
			chk({30'h0, cpuHalt, periphClkOn}, k ? 32'h2 : 32'h3,
				"sleep entered");
			fall(0);
			tick(4);
			chk({30'h0, cpuHalt, periphClkOn}, 32'h1, "woken");
			rdc(`TEI_OFS_STATUS, 32'h1, "wake flag");
			wr(`TEI_OFS_CLEAR, 32'h3f);
		end
		$display("test power modes done");
		wrap_up;
	end
endmodule
